// [verilog/tcc_map.svh]
// register offsets, field positions and reset values of the timer block
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// per channel register offsets, channel index in address bits 7:6
`define TCC_CH_IDX_MSB      7
`define TCC_CH_IDX_LSB      6
`define TCC_OFS_MSB         5
`define TCC_CTRL_OFS        6'h00
`define TCC_MODE_OFS        6'h04
`define TCC_VALUE_OFS       6'h10
`define TCC_STATUS_OFS      6'h20
`define TCC_MASK_OFS        6'h2c

// block level registers
`define TCC_BCTRL_ADDR      8'hc0
`define TCC_BMODE_ADDR      8'hc4
`define TCC_BCFG_ADDR       8'hc8

// channel control register fields (write only commands)
`define TCC_CTRL_CLKEN      0
`define TCC_CTRL_CLKDIS     1
`define TCC_CTRL_SWTRG      2

// channel mode register fields
`define TCC_MODE_W          18
`define TCC_MODE_CLKSEL_LSB 0
`define TCC_MODE_CLKINV     3
`define TCC_MODE_BURST_LSB  4
`define TCC_MODE_BOE        14
`define TCC_MODE_WAVE       15
`define TCC_MODE_AOUT       16
`define TCC_MODE_BOUT       17
`define TCC_MODE_RST        18'h00000

// channel status register fields
`define TCC_ST_OVF          0
`define TCC_ST_CLKON        16
`define TCC_ST_LINE_A       17
`define TCC_ST_LINE_B       18

// block control, block mode and block config fields
`define TCC_BCTRL_SYNC      0
`define TCC_BMODE_W         6
`define TCC_BMODE_RST       6'h00
`define TCC_BCFG_SLOW       0

`endif

// [verilog/tcc_pkg.sv]
// types shared by the timer block
package tcc_pkg;

    typedef enum logic [2:0] {
        TCC_CLK_DIV2   = 3'h0,
        TCC_CLK_DIV8   = 3'h1,
        TCC_CLK_DIV32  = 3'h2,
        TCC_CLK_DIV128 = 3'h3,
        TCC_CLK_SLOW   = 3'h4,
        TCC_CLK_XC0    = 3'h5,
        TCC_CLK_XC1    = 3'h6,
        TCC_CLK_XC2    = 3'h7
    } tcc_clksel_e;

    typedef enum logic [1:0] {
        TCC_BURST_NONE = 2'h0,
        TCC_BURST_XC0  = 2'h1,
        TCC_BURST_XC1  = 2'h2,
        TCC_BURST_XC2  = 2'h3
    } tcc_burst_e;

    typedef enum logic [1:0] {
        TCC_CHAIN_PIN      = 2'h0,
        TCC_CHAIN_NONE     = 2'h1,
        TCC_CHAIN_OTHER_LO = 2'h2,
        TCC_CHAIN_OTHER_HI = 2'h3
    } tcc_chain_e;

    typedef logic [15:0] tcc_count_t;

endpackage

// [verilog/tcc_sync.sv]
// two flip-flop synchroniser with rising edge detect
`timescale 1ns/1ps
module tcc_sync #(
    parameter int WIDTH = 10
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_reset_n,
    // asynchronous inputs
    input  wire logic [WIDTH-1:0] i_async,
    // synchronised level and rising edge pulse
    output logic      [WIDTH-1:0] o_level,
    output logic      [WIDTH-1:0] o_rise
);

    initial
    begin
        if (WIDTH < 1)
            $error("tcc_sync: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] prev_r;

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta_r  <= '0;
            level_r <= '0;
            prev_r  <= '0;
        end
        else
        begin
            meta_r  <= i_async;
            level_r <= meta_r;
            prev_r  <= level_r;
        end
    end

    assign o_level = level_r;
    assign o_rise  = level_r & ~prev_r;

endmodule

// [verilog/tcc_prescaler.sv]
// shared internal clock ticks: master clock /2, /8, /32, /128 and slow clock
`timescale 1ns/1ps
module tcc_prescaler #(
    parameter int DIV_BITS = 7
) (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_reset_n,
    // slow clock rising edge and master clock source
    input  wire logic       i_slow_rise,
    input  wire logic       i_master_from_slow,
    // one-cycle enable per internal clock choice
    output logic      [4:0] o_tick
);

    initial
    begin
        if (DIV_BITS < 7)
            $error("tcc_prescaler: DIV_BITS must be at least 7");
    end

    logic [DIV_BITS-1:0] div_r;
    logic [DIV_BITS-1:0] div_nxt;
    logic [4:0]          tick_r;
    logic [4:0]          tick_nxt;

    always_comb
    begin
        div_nxt  = div_r + {{(DIV_BITS-1){1'b0}}, 1'b1};
        tick_nxt = '0;
        // fifth choice carries the master clock itself when it runs from slow clock
        tick_nxt[4] = i_master_from_slow ? 1'b1 : i_slow_rise;
    end

    // divide by 2, 8, 32, 128: low 1, 3, 5, 7 bits all ones
    for (genvar k = 0; k < 4; k++)
    begin : g_div
        localparam logic [DIV_BITS-1:0] MASK = DIV_BITS'((1 << (2 * k + 1)) - 1);
        always_ff @(posedge i_clock or negedge i_reset_n)
        begin
            if (!i_reset_n)
                tick_r[k] <= 1'b0;
            else
                tick_r[k] <= ((div_r & MASK) == MASK);
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            div_r     <= '0;
            tick_r[4] <= 1'b0;
        end
        else
        begin
            div_r     <= div_nxt;
            tick_r[4] <= tick_nxt[4];
        end
    end

    assign o_tick = tick_r;

endmodule

// [verilog/tcc_timer.sv]
// three channel 16-bit timer with clock selection, chaining and interrupts
//
// Contract
// - three identical independent 16-bit counter channels
// - block control write starts all channels together
// - block mode picks each external clock source
// - internal clocks master /2 /8 /32 /128, slow
// - fifth choice is master clock when slow-sourced
// - three external, five internal clocks, two lines
// - line a input measuring, output in wave
// - line b input measuring, either in wave
// - each channel drives its own interrupt line
// - counter increments on each selected clock edge
// - wrap from maximum to zero sets overflow flag
// - counter value reads live without stopping
// - trigger zeroes count at next valid edge
// - external inputs from pins or other line a
// - clock select field picks among eight clocks
// - invert bit counts on opposite external clock edges
// - burst gates counting on a high external input
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_timer #(
    parameter int CHANNELS = 3,
    parameter int CNT_W    = 16
) (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    // register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // external clock pins and slow clock
    input  wire logic [2:0]  i_ext_clock_pin,
    input  wire logic        i_slow_clock,
    // channel lines
    input  wire logic [2:0]  i_channel_line_a,
    output logic      [2:0]  o_channel_line_a,
    output logic      [2:0]  o_channel_line_a_oe,
    input  wire logic [2:0]  i_channel_line_b,
    output logic      [2:0]  o_channel_line_b,
    output logic      [2:0]  o_channel_line_b_oe,
    // interrupts
    output logic      [2:0]  o_channel_irq,
    output logic             o_irq
);

    initial
    begin
        if (CHANNELS != 3 || CNT_W != 16)
            $error("tcc_timer: logic serves three channels of 16 bits only");
    end

    // pin synchronisers: pins, slow clock, line a, line b
    logic [9:0] sync_lvl;
    logic [9:0] sync_rise;

    tcc_sync #(
        .WIDTH(10)
    ) u_sync (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_async   ({i_channel_line_b, i_channel_line_a, i_slow_clock, i_ext_clock_pin}),
        .o_level   (sync_lvl),
        .o_rise    (sync_rise)
    );

    logic [2:0] pin_lvl;
    logic [2:0] line_a_in;
    logic [2:0] line_b_in;
    assign pin_lvl   = sync_lvl[2:0];
    assign line_a_in = sync_lvl[6:4];
    assign line_b_in = sync_lvl[9:7];

    // block level registers
    logic [`TCC_BMODE_W-1:0] bmode_r;
    logic [`TCC_BMODE_W-1:0] bmode_nxt;
    logic                    slow_src_r;
    logic                    slow_src_nxt;
    logic                    sync_trig;

    logic [7:0] ofs_lo;
    assign ofs_lo = {2'h0, i_addr[`TCC_OFS_MSB:0]};

    always_comb
    begin
        bmode_nxt    = bmode_r;
        slow_src_nxt = slow_src_r;
        if (i_wr && i_addr == `TCC_BMODE_ADDR)
            bmode_nxt = i_wdata[`TCC_BMODE_W-1:0];
        if (i_wr && i_addr == `TCC_BCFG_ADDR)
            slow_src_nxt = i_wdata[`TCC_BCFG_SLOW];
    end

    // one write triggers every channel in the same cycle
    assign sync_trig = i_wr && i_addr == `TCC_BCTRL_ADDR && i_wdata[`TCC_BCTRL_SYNC];

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            bmode_r    <= `TCC_BMODE_RST;
            slow_src_r <= 1'b0;
        end
        else
        begin
            bmode_r    <= bmode_nxt;
            slow_src_r <= slow_src_nxt;
        end
    end

    // shared internal clock ticks
    logic [4:0] int_tick;

    tcc_prescaler #(
        .DIV_BITS(7)
    ) u_prescaler (
        .i_clock            (i_clock),
        .i_reset_n          (i_reset_n),
        .i_slow_rise        (sync_rise[3]),
        .i_master_from_slow (slow_src_r),
        .o_tick             (int_tick)
    );

    // line a level seen by chaining: driven value in wave mode, else pin
    logic [2:0] line_a_lvl;
    logic [2:0] line_a_out_r;
    logic [2:0] wave_r;

    assign line_a_lvl = (wave_r & line_a_out_r) | (~wave_r & line_a_in);

    // external clock inputs routed from pins or other channels' line a
    logic [2:0] xc_lvl;
    logic [2:0] xc_prev_r;
    logic [2:0] xc_rise;
    logic [2:0] xc_fall;

    for (genvar k = 0; k < 3; k++)
    begin : g_xc
        localparam int LO = (k == 0) ? 1 : 0;
        localparam int HI = (k == 2) ? 1 : 2;
        tcc_pkg::tcc_chain_e src;
        assign src = tcc_pkg::tcc_chain_e'(bmode_r[2*k+1:2*k]);
        always_comb
        begin
            unique case (src)
                tcc_pkg::TCC_CHAIN_PIN:      xc_lvl[k] = pin_lvl[k];
                tcc_pkg::TCC_CHAIN_NONE:     xc_lvl[k] = 1'b0;
                tcc_pkg::TCC_CHAIN_OTHER_LO: xc_lvl[k] = line_a_lvl[LO];
                tcc_pkg::TCC_CHAIN_OTHER_HI: xc_lvl[k] = line_a_lvl[HI];
            endcase
        end
        always_ff @(posedge i_clock or negedge i_reset_n)
        begin
            if (!i_reset_n)
                xc_prev_r[k] <= 1'b0;
            else
                xc_prev_r[k] <= xc_lvl[k];
        end
        assign xc_rise[k] = xc_lvl[k] & ~xc_prev_r[k];
        assign xc_fall[k] = ~xc_lvl[k] & xc_prev_r[k];
    end

    // channels
    logic [2:0]                     ch_hit;
    logic [2:0][`TCC_MODE_W-1:0]    mode_r;
    logic [2:0][CNT_W-1:0]          cv_r;
    logic [2:0]                     ovf_r;
    logic [2:0]                     mask_r;
    logic [2:0]                     clken_r;
    logic [2:0]                     irq_r;
    logic [2:0]                     line_b_out_r;
    logic [2:0]                     line_a_oe_r;
    logic [2:0]                     line_b_oe_r;

    for (genvar c = 0; c < 3; c++)
    begin : g_ch
        logic                    started_r;
        logic                    pend_r;
        logic [`TCC_MODE_W-1:0]  mode_nxt;
        logic [CNT_W-1:0]        cv_nxt;
        logic                    ovf_nxt;
        logic                    mask_nxt;
        logic                    clken_nxt;
        logic                    started_nxt;
        logic                    pend_nxt;
        logic                    tick;
        logic                    burst_ok;
        logic                    edge_ok;
        logic                    trig;
        logic                    wr_ctrl;
        tcc_pkg::tcc_clksel_e    sel;
        tcc_pkg::tcc_burst_e     burst;

        assign ch_hit[c] = i_addr[`TCC_CH_IDX_MSB:`TCC_CH_IDX_LSB] == 2'(c);
        assign sel   = tcc_pkg::tcc_clksel_e'(mode_r[c][`TCC_MODE_CLKSEL_LSB +: 3]);
        assign burst = tcc_pkg::tcc_burst_e'(mode_r[c][`TCC_MODE_BURST_LSB +: 2]);
        assign wr_ctrl = i_wr && ch_hit[c] && i_addr[`TCC_OFS_MSB:0] == `TCC_CTRL_OFS;
        assign trig  = (wr_ctrl && i_wdata[`TCC_CTRL_SWTRG]) || sync_trig;

        // selected clock edge as a one-cycle enable
        always_comb
        begin
            unique case (sel)
                tcc_pkg::TCC_CLK_DIV2:   tick = int_tick[0];
                tcc_pkg::TCC_CLK_DIV8:   tick = int_tick[1];
                tcc_pkg::TCC_CLK_DIV32:  tick = int_tick[2];
                tcc_pkg::TCC_CLK_DIV128: tick = int_tick[3];
                tcc_pkg::TCC_CLK_SLOW:   tick = int_tick[4];
                tcc_pkg::TCC_CLK_XC0:    tick = mode_r[c][`TCC_MODE_CLKINV] ? xc_fall[0]
                                                                            : xc_rise[0];
                tcc_pkg::TCC_CLK_XC1:    tick = mode_r[c][`TCC_MODE_CLKINV] ? xc_fall[1]
                                                                            : xc_rise[1];
                tcc_pkg::TCC_CLK_XC2:    tick = mode_r[c][`TCC_MODE_CLKINV] ? xc_fall[2]
                                                                            : xc_rise[2];
            endcase
        end

        always_comb
        begin
            unique case (burst)
                tcc_pkg::TCC_BURST_NONE: burst_ok = 1'b1;
                tcc_pkg::TCC_BURST_XC0:  burst_ok = xc_lvl[0];
                tcc_pkg::TCC_BURST_XC1:  burst_ok = xc_lvl[1];
                tcc_pkg::TCC_BURST_XC2:  burst_ok = xc_lvl[2];
            endcase
        end

        assign edge_ok = tick && burst_ok && clken_r[c];

        always_comb
        begin
            mode_nxt    = mode_r[c];
            mask_nxt    = mask_r[c];
            clken_nxt   = clken_r[c];
            started_nxt = started_r;
            pend_nxt    = pend_r;
            cv_nxt      = cv_r[c];
            ovf_nxt     = ovf_r[c];
            if (i_wr && ch_hit[c] && i_addr[`TCC_OFS_MSB:0] == `TCC_MODE_OFS)
                mode_nxt = i_wdata[`TCC_MODE_W-1:0];
            if (i_wr && ch_hit[c] && i_addr[`TCC_OFS_MSB:0] == `TCC_MASK_OFS)
                mask_nxt = i_wdata[`TCC_ST_OVF];
            if (i_wr && ch_hit[c] && i_addr[`TCC_OFS_MSB:0] == `TCC_STATUS_OFS
                    && i_wdata[`TCC_ST_OVF])
                ovf_nxt = 1'b0;
            if (wr_ctrl && i_wdata[`TCC_CTRL_CLKEN])
                clken_nxt = 1'b1;
            if (wr_ctrl && i_wdata[`TCC_CTRL_CLKDIS])
            begin
                clken_nxt   = 1'b0;
                started_nxt = 1'b0;
            end
            // trigger starts counting only with the clock enabled; zeroing waits for the next valid edge
            if (trig && clken_nxt)
            begin
                started_nxt = 1'b1;
                pend_nxt    = 1'b1;
            end
            if (edge_ok && pend_r)
            begin
                cv_nxt   = '0;
                pend_nxt = trig;
            end
            else if (edge_ok && started_r)
            begin
                cv_nxt = cv_r[c] + CNT_W'(1);
                if (cv_r[c] == {CNT_W{1'b1}})
                    ovf_nxt = 1'b1;
            end
        end

        always_ff @(posedge i_clock or negedge i_reset_n)
        begin
            if (!i_reset_n)
            begin
                mode_r[c]       <= `TCC_MODE_RST;
                mask_r[c]       <= 1'b0;
                clken_r[c]      <= 1'b0;
                started_r       <= 1'b0;
                pend_r          <= 1'b0;
                cv_r[c]         <= '0;
                ovf_r[c]        <= 1'b0;
                irq_r[c]        <= 1'b0;
                wave_r[c]       <= 1'b0;
                line_a_out_r[c] <= 1'b0;
                line_b_out_r[c] <= 1'b0;
                line_a_oe_r[c]  <= 1'b0;
                line_b_oe_r[c]  <= 1'b0;
            end
            else
            begin
                mode_r[c]       <= mode_nxt;
                mask_r[c]       <= mask_nxt;
                clken_r[c]      <= clken_nxt;
                started_r       <= started_nxt;
                pend_r          <= pend_nxt;
                cv_r[c]         <= cv_nxt;
                ovf_r[c]        <= ovf_nxt;
                irq_r[c]        <= ovf_nxt & mask_nxt;
                wave_r[c]       <= mode_nxt[`TCC_MODE_WAVE];
                line_a_out_r[c] <= mode_nxt[`TCC_MODE_AOUT];
                line_b_out_r[c] <= mode_nxt[`TCC_MODE_BOUT];
                line_a_oe_r[c]  <= mode_nxt[`TCC_MODE_WAVE];
                line_b_oe_r[c]  <= mode_nxt[`TCC_MODE_WAVE]
                                   & mode_nxt[`TCC_MODE_BOE];
            end
        end
    end

    // read data for the cycle after the read strobe
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        irq_any_r;
    logic [1:0]  rd_ch;

    assign rd_ch = i_addr[`TCC_CH_IDX_MSB:`TCC_CH_IDX_LSB];

    always_comb
    begin
        rdata_nxt = '0;
        if (i_rd)
        begin
            if (i_addr == `TCC_BMODE_ADDR)
                rdata_nxt = {{(32-`TCC_BMODE_W){1'b0}}, bmode_r};
            else if (i_addr == `TCC_BCFG_ADDR)
                rdata_nxt = {31'h0, slow_src_r};
            else if (rd_ch != 2'h3)
            begin
                unique case (ofs_lo[`TCC_OFS_MSB:0])
                    `TCC_MODE_OFS:
                        rdata_nxt = {{(32-`TCC_MODE_W){1'b0}}, mode_r[rd_ch]};
                    `TCC_VALUE_OFS:
                        rdata_nxt = {16'h0, cv_r[rd_ch]};
                    `TCC_STATUS_OFS:
                    begin
                        rdata_nxt[`TCC_ST_OVF]    = ovf_r[rd_ch];
                        rdata_nxt[`TCC_ST_CLKON]  = clken_r[rd_ch];
                        rdata_nxt[`TCC_ST_LINE_A] = line_a_lvl[rd_ch];
                        rdata_nxt[`TCC_ST_LINE_B] = line_b_in[rd_ch];
                    end
                    `TCC_MASK_OFS:
                        rdata_nxt = {31'h0, mask_r[rd_ch]};
                    default:
                        rdata_nxt = '0;
                endcase
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rdata_r   <= '0;
            irq_any_r <= 1'b0;
        end
        else
        begin
            rdata_r   <= rdata_nxt;
            irq_any_r <= |(ovf_r & mask_r);
        end
    end

    assign o_rdata             = rdata_r;
    assign o_channel_line_a    = line_a_out_r;
    assign o_channel_line_a_oe = line_a_oe_r;
    assign o_channel_line_b    = line_b_out_r;
    assign o_channel_line_b_oe = line_b_oe_r;
    assign o_channel_irq       = irq_r;
    assign o_irq               = irq_any_r;

endmodule

// [testbench/tcc_far_end.sv]
// far side model: clock pins, slow clock and line inputs
`timescale 1ns/1ps
module tcc_far_end (
    // bench controls
    input  wire logic       i_run,
    input  wire logic       i_gate,
    // levels toward the timer
    output logic      [2:0] o_pin,
    output logic            o_slow,
    output logic      [2:0] o_line_a,
    output logic      [2:0] o_line_b
);
    logic clk_x, half;
    assign o_pin = {1'b0, i_gate, clk_x};
    assign o_line_a = 3'h5;
    assign o_line_b = 3'h2;
    // pin 0: 20 ns period, still and low when stopped; slow clock 40 ns
    initial
    begin
        clk_x = 1'b0;
        half = 1'b0;
        o_slow = 1'b0;
        #1.3;
        forever
        begin
            #10;
            clk_x = i_run && !clk_x;
            half = !half;
            o_slow = o_slow ^ half;
        end
    end
endmodule

// [testbench/tcc_timer_assertions.sv]
// port checks of the timer block
`timescale 1ns/1ps
module tcc_timer_checker (
    // clock and reset
    input wire logic        i_clock,
    input wire logic        i_reset_n,
    // register port
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    // lines and interrupts
    input wire logic [2:0]  o_channel_line_a,
    input wire logic [2:0]  o_channel_line_a_oe,
    input wire logic [2:0]  o_channel_line_b_oe,
    input wire logic [2:0]  o_channel_irq,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    wire mode1_wr = i_wr && i_addr == 8'h44;

    property p_rdata_idle;
        !i_rd |=> o_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero");
    property p_value_width;
        i_rd && i_addr[5:0] == 6'h10 |=> o_rdata[31:16] == 16'h0;
    endproperty
    a_value_width: assert property (p_value_width)
        else $error("counter wider than 16 bits");
    property p_irq_any;
        |o_channel_irq |=> o_irq;
    endproperty
    a_irq_any: assert property (p_irq_any)
        else $error("summary interrupt missing");
    property p_irq_mask;
        i_wr && i_addr == 8'hac && !i_wdata[0] |-> ##2 !o_channel_irq[2];
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("masked interrupt still high");
    property p_wave_a;
        mode1_wr && i_wdata[15] |=> o_channel_line_a_oe[1]
            && o_channel_line_a[1] == $past(i_wdata[16]);
    endproperty
    a_wave_a: assert property (p_wave_a)
        else $error("line a not driven in wave mode");
    property p_meas;
        mode1_wr && !i_wdata[15] |=> !o_channel_line_a_oe[1] && !o_channel_line_b_oe[1];
    endproperty
    a_meas: assert property (p_meas)
        else $error("line driven in measurement mode");
    property p_wave_b;
        mode1_wr && i_wdata[15] |=> o_channel_line_b_oe[1] == $past(i_wdata[14]);
    endproperty
    a_wave_b: assert property (p_wave_b)
        else $error("line b enable wrong in wave mode");
    property p_b_needs_wave;
        (o_channel_line_b_oe & ~o_channel_line_a_oe) == 3'h0;
    endproperty
    a_b_needs_wave: assert property (p_b_needs_wave)
        else $error("line b driven outside wave mode");
endmodule

bind tcc_timer tcc_timer_checker u_chk (
    .i_clock, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_channel_line_a,
    .o_channel_line_a_oe, .o_channel_line_b_oe, .o_channel_irq, .o_irq
);

// [testbench/tb.sv]
// self-checking bench of the three channel timer
`timescale 1ns/1ps
module tb;
    logic        i_clock = 1'b0;
    logic        i_reset_n, i_wr, i_rd, i_slow_clock, o_irq, run, gate;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [2:0]  i_ext_clock_pin, o_channel_line_a, o_channel_line_a_oe, far_a, far_b;
    logic [2:0]  o_channel_line_b, o_channel_line_b_oe, o_channel_irq;
    wire  [2:0]  i_channel_line_a = (o_channel_line_a_oe & o_channel_line_a)
                                    | (~o_channel_line_a_oe & far_a);
    wire  [2:0]  i_channel_line_b = (o_channel_line_b_oe & o_channel_line_b)
                                    | (~o_channel_line_b_oe & far_b);
    int          n_mismatch = 0, comparisons = 0, cycles = 0;

    tcc_timer u_dut (.i_clock, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_ext_clock_pin, .i_slow_clock, .i_channel_line_a, .o_channel_line_a,
        .o_channel_line_a_oe, .i_channel_line_b, .o_channel_line_b, .o_channel_line_b_oe,
        .o_channel_irq, .o_irq);
    tcc_far_end u_far (.i_run(run), .i_gate(gate), .o_pin(i_ext_clock_pin),
        .o_slow(i_slow_clock), .o_line_a(far_a), .o_line_b(far_b));

    always #2.5 i_clock = ~i_clock;

    task automatic tally_and_finish();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    task automatic rd_reg(logic [7:0] a, output logic [31:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic settle(int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic start(logic [7:0] b);
        wr_reg(b, 32'h5);
        settle(130);
    endtask

    task automatic rate(logic [7:0] b, int gap, logic [15:0] exp);
        logic [31:0] v0, v1;
        rd_reg(b + 8'h10, v0);
        repeat (gap - 2) @(posedge i_clock);
        rd_reg(b + 8'h10, v1);
        chk("count rate", {16'h0, v1[15:0] - v0[15:0]}, {16'h0, exp});
    endtask

    task automatic pulse_a1();
        wr_reg(8'h44, 32'h00018000);
        settle(6);
        wr_reg(8'h44, 32'h00008000);
        settle(6);
    endtask

    task automatic t_regs();
        logic [31:0] v;
        rd_reg(8'h04, v);
        chk("mode reset", v, 32'h0);
        wr_reg(8'h84, 32'h0003c03f);
        rd_reg(8'h84, v);
        chk("mode readback", v, 32'h0003c03f);
        rd_reg(8'hfc, v);
        chk("unmapped", v, 32'h0);
    endtask

    task automatic t_internal();
        logic [7:0] b;
        for (int s = 0; s < 4; s++)
        begin
            b = 8'((s % 3) << 6);
            wr_reg(b + 8'h04, 32'(s));
            start(b);
            rate(b, 256, 16'(128 >> (2 * s)));
            wr_reg(b, 32'h2);
        end
    endtask

    task automatic t_slow();
        wr_reg(8'h44, 32'h4);
        start(8'h40);
        rate(8'h40, 256, 16'h20);
        wr_reg(8'hc8, 32'h1);
        settle(4);
        rate(8'h40, 256, 16'h100);
        wr_reg(8'h40, 32'h2);
    endtask

    task automatic t_ext();
        wr_reg(8'h04, 32'h5);
        start(8'h00);
        run <= 1'b1;
        settle(8);
        rate(8'h00, 256, 16'h40);
        wr_reg(8'h04, 32'h0d);
        rate(8'h00, 256, 16'h40);
        wr_reg(8'h04, 32'h20);
        rate(8'h00, 256, 16'h0);
        gate <= 1'b1;
        settle(8);
        rate(8'h00, 256, 16'h80);
        run <= 1'b0;
        gate <= 1'b0;
    endtask

    task automatic t_chain();
        logic [31:0] v;
        wr_reg(8'h44, 32'h00008000);
        wr_reg(8'hc4, 32'h2);
        wr_reg(8'h04, 32'h5);
        start(8'h00);
        settle(8);
        rd_reg(8'h10, v);
        chk("held after trigger", 32'(v[15:0] != 16'h0), 32'h1);
        pulse_a1();
        rd_reg(8'h10, v);
        chk("zero at first edge", v, 32'h0);
        repeat (3) pulse_a1();
        rd_reg(8'h10, v);
        chk("chained count", v, 32'h3);
        wr_reg(8'h44, 32'h0003c000);
        settle(2);
        chk("wave lines", 32'({o_channel_line_a_oe[1], o_channel_line_a[1],
            o_channel_line_b_oe[1], o_channel_line_b[1]}), 32'hf);
        wr_reg(8'h44, 32'h0);
        settle(2);
        chk("measure lines", 32'({o_channel_line_a_oe[1], o_channel_line_b_oe[1]}),
            32'h0);
        wr_reg(8'hc4, 32'h0);
        wr_reg(8'h00, 32'h2);
    endtask

    task automatic t_sync();
        logic [31:0] v0, v1, v2;
        for (int c = 0; c < 3; c++)
        begin
            wr_reg(8'(c << 6) + 8'h04, 32'h4);
            wr_reg(8'(c << 6), 32'h1);
        end
        wr_reg(8'hc0, 32'h1);
        settle(4);
        rd_reg(8'h10, v0);
        rd_reg(8'h50, v1);
        rd_reg(8'h90, v2);
        chk("sync 0 to 1", v1 - v0, 32'h2);
        chk("sync 1 to 2", v2 - v1, 32'h2);
        wr_reg(8'h00, 32'h2);
        wr_reg(8'h40, 32'h2);
    endtask

    task automatic t_irq();
        logic [31:0] v;
        wr_reg(8'hac, 32'h1);
        for (int i = 0; i < 70000 && o_channel_irq[2] !== 1'b1; i++)
            @(posedge i_clock);
        settle(2);
        chk("irq lines", 32'({o_irq, o_channel_irq}), 32'hc);
        wr_reg(8'h80, 32'h2);
        rd_reg(8'ha0, v);
        chk("overflow flag", v & 32'h1, 32'h1);
        wr_reg(8'hac, 32'h0);
        settle(3);
        chk("masked", 32'({o_irq, o_channel_irq}), 32'h0);
        wr_reg(8'hac, 32'h1);
        settle(3);
        chk("unmasked", 32'(o_channel_irq), 32'h4);
        wr_reg(8'ha0, 32'h1);
        rd_reg(8'ha0, v);
        settle(2);
        chk("cleared", 32'({o_irq, o_channel_irq}) | (v & 32'h1), 32'h0);
    endtask

    initial
    begin
        {i_reset_n, i_addr, i_wdata, i_wr, i_rd, run, gate} = '0;
        repeat (20) @(posedge i_clock);
        i_reset_n <= 1'b1;
        t_regs();
        t_internal();
        t_slow();
        t_ext();
        t_chain();
        t_sync();
        t_irq();
        tally_and_finish();
    end
endmodule
